// file: logic/lecs_pkg.sv
package lecs_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [11:0] LECS_IDX_HOLD1   = 12'h489;
    localparam logic [11:0] LECS_IDX_HOLD2   = 12'h48a;
    localparam logic [11:0] LECS_IDX_HOLD3   = 12'h48b;
    // Own registers for counters, status, mask and control
    localparam logic [11:0] LECS_IDX_CNT1    = 12'h500;
    localparam logic [11:0] LECS_IDX_CNT2    = 12'h501;
    localparam logic [11:0] LECS_IDX_CNT3    = 12'h502;
    localparam logic [11:0] LECS_IDX_CNTRST  = 12'h503;
    localparam logic [11:0] LECS_IDX_IRQSTAT = 12'h504;
    localparam logic [11:0] LECS_IDX_IRQMASK = 12'h505;
    // Field positions inside a hold field and a counter word
    localparam int          LECS_BIT_UCC     = 2;
    localparam int          LECS_BIT_CGI     = 1;
    localparam int          LECS_BIT_RDE     = 0;
    localparam int          LECS_CNT_W       = 8;
    // Reset values and counter top value
    localparam logic [2:0]  LECS_HOLD_RST    = 3'h7;
    localparam logic [7:0]  LECS_CNT_MAX     = 8'hff;
    localparam logic [8:0]  LECS_MASK_RST    = 9'h000;
    // Bus answer state
    typedef enum logic [1:0] {
        LECS_IDLE = 2'b01,
        LECS_DONE = 2'b10
    } lecs_bus_t;
endpackage

// file: logic/lecs_counter_bank.sv
// Functional notes
// - Hold enabled: counter stops at 0xff.
// - Hold disabled: counter wraps to zero.
// - Bit2 control char, bit1 table, bit0 disparity.
// - Hold bits 2:0, reset ones, reserved zero.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module lecs_counter_bank
    import lecs_pkg::*;
#(
    parameter int LANES = 3
) (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // Avalon-MM slave, word addressed by byte address bits
    input  wire logic [13:0]         avsAddress,
    input  wire logic                avsRead,
    input  wire logic                avsWrite,
    input  wire logic [31:0]         avsWriteData,
    input  wire logic [3:0]          avsByteEnable,
    output logic      [31:0]         avsReadData,
    output logic                     avsWaitRequest,
    output logic      [1:0]          avsResponse,
    // Error events per lane, bit order as in a hold field
    input  wire logic [3*LANES-1:0]  laneErrorEvent,
    // Hold field copy for the deframer
    output logic      [3*LANES-1:0]  laneHoldField,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////
    // State
    // Everything the block remembers lives in this one record, so the
    // reset branch and the register stage stay in one place.
    // Bus phase: idle until a request is taken, then one answer cycle.
    // Read data and response are registered at the taking edge and
    // stand until the next answer replaces them.
    // Hold bits keep the lane order of the error event bus, so index
    // 3*(lane-1)+k is the same counter everywhere in this file.
    // Counters are plain flip-flops; no memory macro is worth it for
    // nine bytes, and flops let every counter step in the same cycle.
    typedef struct packed {
        lecs_bus_t                   bus;     // Answer phase
        logic [31:0]                 rdata;   // Registered read data
        logic [1:0]                  resp;    // Registered response
        logic [3*LANES-1:0]          hold;    // Hold fields, all lanes
        logic [3*LANES-1:0][7:0]     cnt;     // Error counters
        logic [3*LANES-1:0]          stat;    // Sticky wrap/saturate
        logic [3*LANES-1:0]          mask;    // Interrupt mask
    } lecs_state_t;

    lecs_state_t state_ff;
    lecs_state_t nxt_state;

    // Word index from byte address
    // Byte lanes below the word are ignored; software is expected to
    // issue aligned word accesses only.
    logic [11:0] wordIdx;
    assign wordIdx = avsAddress[13:2];

    // Next counter value, honouring hold or wrap
    // Clear beats an event in the same cycle, so a reset strobe always
    // leaves the counter at zero even under a storm of errors.
    // With hold set the counter freezes at the top and later events of
    // its type are dropped; the held value stays readable.
    // With hold clear the add simply overflows, which is the roll-over
    // back to zero that software asked for.
    // Used for all nine counters, hence a function.
    function automatic logic [7:0] cnt_next(input logic [7:0] c,
                                            input logic       ev,
                                            input logic       hold,
                                            input logic       clr);
        logic [7:0] r;
        r = c;
        if (clr) begin
            r = 8'h00;
        end else if (ev && !(hold && c == LECS_CNT_MAX)) begin
            r = c + 8'h01;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state
    // Starts from the present state and changes only what this cycle
    // touches, so every field has a value on every path.
    // A write takes effect at the taking edge, while the bus is idle;
    // the answer cycle that follows repeats nothing, even though the
    // master still holds its request there.
    // Hold fields are not locked outside deframer soft reset: keeping
    // to that window is the duty of software, and a lock would need a
    // control input this block does not have.
    // Status bits are set when a counter steps from 0xfe to 0xff, in
    // hold and wrap mode alike; a set in the same cycle as a
    // write-one-to-clear wins, so no event is lost.
    always_comb begin
        logic         acc;
        logic         wr;
        logic [31:0]  rd;
        logic [1:0]   rs;
        logic [8:0]   clrCnt;
        acc    = avsRead | avsWrite;
        wr     = avsWrite && state_ff.bus == LECS_IDLE;
        rd     = 32'h0000_0000;
        rs     = 2'h0;
        clrCnt = 9'h000;
        nxt_state = state_ff;
        // Counter reset strobe is a write-only pulse register
        if (wr && wordIdx == LECS_IDX_CNTRST && avsByteEnable[0]) begin
            clrCnt = avsWriteData[8:0];
        end
        // Counters: held at max (event lost) or wrap to zero
        for (int i = 0; i < 3*LANES; i++) begin
            nxt_state.cnt[i] = cnt_next(state_ff.cnt[i],
                laneErrorEvent[i], state_ff.hold[i], clrCnt[i]);
            // Sticky on reaching max; set wins over clear
            if (laneErrorEvent[i] && !clrCnt[i]
                && state_ff.cnt[i] == 8'hfe) begin
                nxt_state.stat[i] = 1'b1;
            end else if (wr && wordIdx == LECS_IDX_IRQSTAT
                         && avsWriteData[i]) begin
                nxt_state.stat[i] = 1'b0;
            end
        end
        // Register decode
        case (wordIdx)
            LECS_IDX_HOLD1, LECS_IDX_HOLD2, LECS_IDX_HOLD3: begin
                // Software keeps to deframer soft reset when writing
                rd[2:0] = state_ff.hold[3*(wordIdx-LECS_IDX_HOLD1) +: 3];
                if (wr && avsByteEnable[0]) begin
                    nxt_state.hold[3*(wordIdx-LECS_IDX_HOLD1) +: 3] =
                        avsWriteData[2:0];
                end
            end
            LECS_IDX_CNT1, LECS_IDX_CNT2, LECS_IDX_CNT3: begin
                // Bits 23:16 control char, 15:8 table, 7:0 disparity
                rd[23:0] = state_ff.cnt[3*(wordIdx-LECS_IDX_CNT1) +: 3];
            end
            LECS_IDX_CNTRST: begin
                rd = 32'h0000_0000;
            end
            LECS_IDX_IRQSTAT: begin
                rd[8:0] = state_ff.stat;
            end
            LECS_IDX_IRQMASK: begin
                rd[8:0] = state_ff.mask;
                if (wr && avsByteEnable[0]) begin
                    nxt_state.mask[7:0] = avsWriteData[7:0];
                end
                if (wr && avsByteEnable[1]) begin
                    nxt_state.mask[8] = avsWriteData[8];
                end
            end
            default: begin
                // Unmapped: reads zero, slave error response
                rs = 2'h2;
            end
        endcase
        // One wait cycle, then answer
        case (state_ff.bus)
            LECS_IDLE: begin
                if (acc) begin
                    nxt_state.bus   = LECS_DONE;
                    nxt_state.rdata = rd;
                    nxt_state.resp  = rs;
                end
            end
            LECS_DONE: begin
                nxt_state.bus = LECS_IDLE;
            end
            default: begin
                nxt_state.bus = LECS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    // Synchronous reset only; the reset branch loads constants.
    // Hold bits come up as all ones, so every counter saturates until
    // software chooses roll-over for it.
    // Counters, status and mask come up clear, so the interrupt output
    // is low straight out of reset.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff.bus   <= LECS_IDLE;
            state_ff.rdata <= 32'h0000_0000;
            state_ff.resp  <= 2'h0;
            state_ff.hold  <= {LANES{LECS_HOLD_RST}};
            state_ff.cnt   <= '0;
            state_ff.stat  <= '0;
            state_ff.mask  <= LECS_MASK_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    // Waitrequest is combinational so that it follows the request in
    // the taking cycle; it drops only in the answer cycle.
    // Data outputs come straight from flip-flops.
    // The interrupt is a level: high while any unmasked sticky status
    // bit is set, low again once software clears or masks it.
    // The hold copy feeds the deframer directly, with no extra stage.
    assign avsWaitRequest = (avsRead | avsWrite)
                            && state_ff.bus != LECS_DONE;
    assign avsReadData    = state_ff.rdata;
    assign avsResponse    = state_ff.resp;
    assign laneHoldField  = state_ff.hold;
    assign irq            = |(state_ff.stat & state_ff.mask);

endmodule

`default_nettype wire

// file: verif/lecs_counter_bank_sva.sv
`timescale 1ns/100ps
`default_nettype none
module lecs_counter_bank_sva
    import lecs_pkg::*;
#(parameter int LANES = 3) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [13:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    input wire logic [3*LANES-1:0] laneHoldField
);
    wire logic ack = (avsRead || avsWrite) && !avsWaitRequest; // Answer
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence req_s; (avsRead || avsWrite) && avsWaitRequest; endsequence
    sequence h1_s; ack && avsAddress == {LECS_IDX_HOLD1, 2'h0}; endsequence
    wait_one_a: assert property (req_s |=> !avsWaitRequest)
        else $error("no answer in cycle one");
    hold_rst_a: assert property ($fell(reset) |-> &laneHoldField)
        else $error("hold field not ones after reset");
    hold_wr_a: assert property (h1_s ##0 avsWrite |=>
        laneHoldField[2:0] == $past(avsWriteData[2:0]))
        else $error("hold write lost");
    hold_rd_a: assert property (h1_s ##0 avsRead |->
        avsReadData == {29'h0, laneHoldField[2:0]}) else $error("hold read");
    hold_keep_a: assert property (!avsWrite |=> $stable(laneHoldField))
        else $error("hold field moved without a write");
endmodule
bind lecs_counter_bank lecs_counter_bank_sva #(.LANES(LANES)) u_sva (.*);
`default_nettype wire

// file: verif/lecs_counter_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lecs_counter_bank_tb
    import lecs_pkg::*;;
    logic ref_clk = 1'h0, reset = 1'h1, avsRead = 1'h0, avsWrite = 1'h0;
    logic irq, avsWaitRequest;
    logic [1:0] avsResponse;
    logic [3:0] avsByteEnable = 4'hf; // Whole words only
    logic [8:0] laneErrorEvent = 9'h000, laneHoldField;
    logic [13:0] avsAddress = 14'h0000;
    logic [31:0] avsWriteData = 32'h0, avsReadData;
    int n_fail = 0, compares = 0;
    always #25 ref_clk = ~ref_clk; // 20 MHz
    lecs_counter_bank u_dut (.*);
    task automatic chk(input logic [31:0] got, exp);
        compares++;
        n_fail += int'(got !== exp);
        if (got !== exp) $display("unexpected %0t %h %h", $time, got, exp);
    endtask
    // Held until answered; the watchdog bounds a hang
    task automatic bus(input logic w, logic [11:0] i, logic [31:0] d, e);
        {avsRead, avsWrite, avsAddress, avsWriteData} <= {!w, w, i, 2'h0, d};
        do @(posedge ref_clk); while (avsWaitRequest !== 1'h0);
        if (!w) chk(avsReadData, e);
        {avsRead, avsWrite} <= 2'h0;
        @(posedge ref_clk);
    endtask
    task automatic t_regs;
        bus(1, LECS_IDX_HOLD1, 32'hfffffffd, 32'h0);
        bus(0, LECS_IDX_HOLD1, 32'h0, 32'h5);
        chk({30'h0, avsResponse}, 32'h0);
        chk({23'h0, laneHoldField}, 32'h1fd);
        bus(0, 12'h48c, 32'h0, 32'h0); // Unmapped reads zero
        chk({30'h0, avsResponse}, 32'h2);
    endtask
    // Lane 1 table count wraps, the other two stick at the top
    task automatic t_count;
        laneErrorEvent <= 9'h007;
        repeat (257) @(posedge ref_clk);
        laneErrorEvent <= 9'h000;
        bus(0, LECS_IDX_CNT1, 32'h0, 32'hff01ff);
        bus(1, LECS_IDX_IRQMASK, 32'h4, 32'h0);
        bus(0, LECS_IDX_IRQSTAT, 32'h0, 32'h7);
        chk({31'h0, irq}, 32'h1);
        bus(1, LECS_IDX_IRQSTAT, 32'h4, 32'h0);
        bus(0, LECS_IDX_IRQSTAT, 32'h0, 32'h3);
        chk({31'h0, irq}, 32'h0);
        bus(1, LECS_IDX_CNTRST, 32'h7, 32'h0);
        bus(0, LECS_IDX_CNT1, 32'h0, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'h0;
        t_regs;
        t_count;
        print_verdict;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        print_verdict;
    end
    task automatic print_verdict;
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
endmodule
`default_nettype wire
